// ===== shared/ssr_params.svh
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// Serial command value of the table read
`define SSR_OPC_READ 8'h5A
// Table geometry
`define SSR_TBL_DEPTH 256
`define SSR_AW 8
// Last value of the bit counter in each phase
`define SSR_CMD_LAST 5'h07
`define SSR_ADDR_LAST 5'h17
`define SSR_DUMMY_LAST 5'h07
`define SSR_BIT_LAST 5'h07
// Reset values
`define SSR_BYTE_RST 8'h00
`define SSR_CNT_RST 5'h00

`endif

// ===== shared/ssr_pkg.sv
`include "ssr_params.svh"

package ssr_pkg;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } ssr_state_e;

  typedef struct packed {
    logic [`SSR_AW-1:0] addr;
    logic [7:0] data;
  } ssr_word_s;

endpackage

// ===== core/ssr_buf2.sv
`timescale 1ns/1ps

module ssr_buf2
(
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic flush_in, // Drop all entries
  input wire logic in_valid_in, // Write side valid
  output logic in_ready_out, // Write side ready
  input wire ssr_pkg::ssr_word_s in_data_in, // Write side word
  output logic out_valid_out, // Read side valid
  input wire logic out_ready_in, // Read side ready
  output ssr_pkg::ssr_word_s out_data_out // Read side word
);

  ssr_pkg::ssr_word_s mem_ff [2];
  ssr_pkg::ssr_word_s nxt_mem [2];
  logic wp_ff;
  logic rp_ff;
  logic [1:0] cnt_ff;
  logic nxt_wp;
  logic nxt_rp;
  logic [1:0] nxt_cnt;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_ff != 2'h2);
  assign out_valid_out = (cnt_ff != 2'h0);
  assign out_data_out = mem_ff[rp_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (flush_in)
    begin
      nxt_wp = 1'b0;
      nxt_rp = 1'b0;
      nxt_cnt = 2'h0;
    end
    else
    begin
      if (push)
      begin
        nxt_mem[wp_ff] = in_data_in;
        nxt_wp = ~wp_ff;
      end
      if (pop)
      begin
        nxt_rp = ~rp_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ===== core/ssr_core.sv
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_core
(
  input wire logic mclk_in, // System clock, 40 MHz
  input wire logic nrst_in, // Async reset, active low
  input wire logic sck_in, // Serial clock from the host
  input wire logic cs_n_in, // Chip select, active low
  input wire logic si_in, // Serial data in
  output logic so_out, // Serial data out
  output logic so_oe_out, // Serial out drive enable, high drives
  input wire logic tbl_wr_in, // Table load strobe, system clock
  input wire logic [`SSR_AW-1:0] tbl_addr_in, // Table load address
  input wire logic [7:0] tbl_data_in // Table load byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  ssr_pkg::ssr_state_e st_ff, nxt_st;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [6:0] in_sh_ff, nxt_in_sh;
  logic [7:0] osh_ff, nxt_osh;
  logic oe_ff, nxt_oe;
  logic [7:0] stage_ff, nxt_stage;
  logic stage_vld_ff, nxt_stage_vld;
  logic [`SSR_AW-1:0] exp_ff, nxt_exp;
  logic [`SSR_AW-1:0] req_addr_ff, nxt_req_addr;
  logic req_tgl_ff, nxt_req_tgl;
  logic ack_tgl_ff, nxt_ack_tgl;
  logic hs1_ff;
  logic hs2_ff;
  logic frm_rst_n;
  logic [7:0] in_word;
  logic hold_pend;
  logic take;

  // System clock side, declared here because the serial side reads them
  ssr_pkg::ssr_word_s hold_ff, nxt_hold;
  logic hold_tgl_ff, nxt_hold_tgl;

  assign frm_rst_n = nrst_in & ~cs_n_in;
  assign in_word = {in_sh_ff, si_in};
  assign hold_pend = hs2_ff ^ ack_tgl_ff;
  assign take = hold_pend && !stage_vld_ff && (st_ff == ssr_pkg::ST_DUMMY ||
                st_ff == ssr_pkg::ST_DATA);
  assign so_out = osh_ff[7];
  assign so_oe_out = oe_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 5'h01;
    nxt_in_sh = in_word[6:0];
    nxt_osh = osh_ff;
    nxt_oe = oe_ff;
    nxt_stage = stage_ff;
    nxt_stage_vld = stage_vld_ff;
    nxt_exp = exp_ff;
    nxt_req_addr = req_addr_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_ack_tgl = ack_tgl_ff;
    case (st_ff)
      ssr_pkg::ST_CMD:
      begin
        if (cnt_ff == `SSR_CMD_LAST)
        begin
          nxt_cnt = `SSR_CNT_RST;
          if (in_word == `SSR_OPC_READ)
            nxt_st = ssr_pkg::ST_ADDR;
          else
            nxt_st = ssr_pkg::ST_IGNORE;
        end
      end
      ssr_pkg::ST_ADDR:
      begin
        if (cnt_ff == `SSR_ADDR_LAST)
        begin
          // Upper address bits fall outside the table and are dropped
          nxt_cnt = `SSR_CNT_RST;
          nxt_st = ssr_pkg::ST_DUMMY;
          nxt_req_addr = in_word;
          nxt_exp = in_word;
          nxt_req_tgl = ~req_tgl_ff;
        end
      end
      ssr_pkg::ST_DUMMY:
      begin
        if (cnt_ff == `SSR_DUMMY_LAST)
        begin
          nxt_cnt = `SSR_CNT_RST;
          nxt_st = ssr_pkg::ST_DATA;
          nxt_oe = 1'b1;
          nxt_osh = stage_ff;
          nxt_stage_vld = 1'b0;
        end
      end
      ssr_pkg::ST_DATA:
      begin
        nxt_osh = {osh_ff[6:0], 1'b0};
        if (cnt_ff == `SSR_BIT_LAST)
        begin
          // Next byte loads on the same edge, so no gap at any boundary
          nxt_cnt = `SSR_CNT_RST;
          nxt_osh = stage_ff;
          nxt_stage_vld = 1'b0;
        end
      end
      default:
      begin
        nxt_cnt = cnt_ff;
      end
    endcase
    // Stale words from an earlier frame carry the wrong address and are dropped
    if (take)
    begin
      nxt_ack_tgl = ~ack_tgl_ff;
      if (hold_ff.addr == exp_ff)
      begin
        nxt_stage = hold_ff.data;
        nxt_stage_vld = 1'b1;
        nxt_exp = exp_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge sck_in or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      st_ff <= ssr_pkg::ST_CMD;
      cnt_ff <= `SSR_CNT_RST;
      in_sh_ff <= 7'h00;
      osh_ff <= `SSR_BYTE_RST;
      oe_ff <= 1'b0;
      stage_ff <= `SSR_BYTE_RST;
      stage_vld_ff <= 1'b0;
      exp_ff <= 8'h00;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      in_sh_ff <= nxt_in_sh;
      osh_ff <= nxt_osh;
      oe_ff <= nxt_oe;
      stage_ff <= nxt_stage;
      stage_vld_ff <= nxt_stage_vld;
      exp_ff <= nxt_exp;
    end
  end

  // Crossing state survives frames so both toggles stay paired
  always_ff @(posedge sck_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      req_addr_ff <= 8'h00;
      req_tgl_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
      hs1_ff <= 1'b0;
      hs2_ff <= 1'b0;
    end
    else
    begin
      req_addr_ff <= nxt_req_addr;
      req_tgl_ff <= nxt_req_tgl;
      ack_tgl_ff <= nxt_ack_tgl;
      hs1_ff <= hold_tgl_ff;
      hs2_ff <= hs1_ff;
    end
  end

  sequence dummy_quiet_s;
    (!oe_ff) [*8];
  endsequence

  sequence data_start_s;
    oe_ff && st_ff == ssr_pkg::ST_DATA;
  endsequence

  opcode_accept_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (st_ff == ssr_pkg::ST_CMD && cnt_ff == `SSR_CMD_LAST && in_word == `SSR_OPC_READ)
    |=> st_ff == ssr_pkg::ST_ADDR)
    else $error("read opcode not decoded");

  opcode_reject_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (st_ff == ssr_pkg::ST_CMD && cnt_ff == `SSR_CMD_LAST && in_word != `SSR_OPC_READ)
    |=> st_ff == ssr_pkg::ST_IGNORE ##1 st_ff == ssr_pkg::ST_IGNORE)
    else $error("foreign opcode not ignored");

  addr_capture_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (st_ff == ssr_pkg::ST_ADDR && cnt_ff == `SSR_ADDR_LAST)
    |=> req_addr_ff == $past(in_word) && req_tgl_ff != $past(req_tgl_ff)
        && st_ff == ssr_pkg::ST_DUMMY)
    else $error("start address not captured");

  dummy_length_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (st_ff == ssr_pkg::ST_DUMMY && cnt_ff == `SSR_CNT_RST) |-> dummy_quiet_s ##1 data_start_s)
    else $error("output did not start after dummy byte");

  hiz_before_data_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    st_ff != ssr_pkg::ST_DATA |-> !so_oe_out)
    else $error("output driven before data phase");

  byte_msb_first_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (st_ff == ssr_pkg::ST_DATA && cnt_ff == `SSR_BIT_LAST)
    |=> so_out == $past(stage_ff[7]) ##1 so_out == $past(stage_ff[6], 2))
    else $error("byte not shifted msb first");

  addr_advance_a: assert property (
    @(posedge sck_in) disable iff (!frm_rst_n)
    (take && hold_ff.addr == exp_ff) |=> exp_ff == $past(exp_ff) + 8'h01 && stage_vld_ff)
    else $error("byte address did not advance with wrap");

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain

  logic [7:0] tbl_mem [`SSR_TBL_DEPTH];
  logic rs1_ff, rs2_ff, rseen_ff, nxt_rseen;
  logic as1_ff, as2_ff;
  logic [`SSR_AW-1:0] fptr_ff, nxt_fptr;
  logic act_ff, nxt_act;
  logic new_req;
  logic push_vld;
  logic push_rdy;
  logic pop_vld;
  logic pop_rdy;
  ssr_pkg::ssr_word_s push_word;
  ssr_pkg::ssr_word_s pop_word;

  // Load port is the only writer; the serial side can only read
  always_ff @(posedge mclk_in)
  begin
    if (tbl_wr_in)
      tbl_mem[tbl_addr_in] <= tbl_data_in;
  end

  assign new_req = rs2_ff ^ rseen_ff;
  assign push_vld = act_ff && !new_req;
  assign push_word = '{addr: fptr_ff, data: tbl_mem[fptr_ff]};
  assign pop_rdy = (hold_tgl_ff == as2_ff);

  always_comb
  begin
    nxt_rseen = rs2_ff;
    nxt_fptr = fptr_ff;
    nxt_act = act_ff;
    nxt_hold = hold_ff;
    nxt_hold_tgl = hold_tgl_ff;
    if (new_req)
    begin
      // Address word is stable: it changes only once per frame
      nxt_fptr = req_addr_ff;
      nxt_act = 1'b1;
    end
    else if (push_vld && push_rdy)
    begin
      nxt_fptr = fptr_ff + 8'h01;
    end
    if (pop_vld && pop_rdy)
    begin
      // Prefetch runs ahead so bytes keep up with the serial clock
      nxt_hold = pop_word;
      nxt_hold_tgl = ~hold_tgl_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
      rseen_ff <= 1'b0;
      as1_ff <= 1'b0;
      as2_ff <= 1'b0;
      fptr_ff <= 8'h00;
      act_ff <= 1'b0;
      hold_ff <= '0;
      hold_tgl_ff <= 1'b0;
    end
    else
    begin
      rs1_ff <= req_tgl_ff;
      rs2_ff <= rs1_ff;
      rseen_ff <= nxt_rseen;
      as1_ff <= ack_tgl_ff;
      as2_ff <= as1_ff;
      fptr_ff <= nxt_fptr;
      act_ff <= nxt_act;
      hold_ff <= nxt_hold;
      hold_tgl_ff <= nxt_hold_tgl;
    end
  end

  ssr_buf2 ssr_buf2_i
  (
    .clk_in(mclk_in),
    .rst_n_in(nrst_in),
    .flush_in(new_req),
    .in_valid_in(push_vld),
    .in_ready_out(push_rdy),
    .in_data_in(push_word),
    .out_valid_out(pop_vld),
    .out_ready_in(pop_rdy),
    .out_data_out(pop_word)
  );

  fetch_wrap_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (push_vld && push_rdy) |=> fptr_ff == $past(fptr_ff) + 8'h01)
    else $error("fetch pointer did not advance with wrap");

  fetch_restart_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    new_req |=> fptr_ff == $past(req_addr_ff) && act_ff && !pop_vld)
    else $error("fetch did not restart at start address");

  hold_stable_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (hold_tgl_ff != as2_ff) |=> $stable(hold_ff) && $stable(hold_tgl_ff))
    else $error("hold word changed while unacknowledged");

endmodule

// ===== tb/ssr_host.sv
`timescale 1ns/1ps

module ssr_host
(
  input wire logic so_in, // Serial data from device
  input wire logic so_oe_in, // Device drive enable
  output logic sck_out, // Serial clock
  output logic cs_n_out, // Chip select, active low
  output logic si_out // Serial data to device
);
  int hp;
  int early_oe;
  int lost_oe;
  logic [7:0] rx [0:259];

  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hp = 32;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame; clock only runs inside it, bit count set here
  task automatic xfer(input logic [7:0] opc, input logic [23:0] adr, input int nbits);
    logic [39:0] hdr;
    int e;
    hdr = {opc, adr, 8'hC3};
    early_oe = 0;
    lost_oe = 0;
    // Select stays high for two half periods before it falls to start the frame
    #(2 * hp);
    cs_n_out = 1'b0;
    #(2 * hp);
    for (e = 1; e < 40 + nbits; e++)
    begin
      si_out = (e <= 40) ? hdr[40 - e] : ~si_out;
      #hp sck_out = 1'b1;
      #hp;
      if (e < 40 && so_oe_in !== 1'b0)
        early_oe++;
      if (e >= 40)
      begin
        if (so_oe_in !== 1'b1)
          lost_oe++;
        // A floating line reads back as the inverse of so_in
        rx[(e - 40) / 8] = {rx[(e - 40) / 8][6:0], (so_oe_in === 1'b1) ? so_in : ~so_in};
      end
      sck_out = 1'b0;
    end
    #hp cs_n_out = 1'b1;
    si_out = ~si_out;
  endtask
endmodule

// ===== tb/ssr_core_tb.sv
`timescale 1ns/1ps

module ssr_core_tb;
  logic mclk_in;
  logic nrst_in;
  logic tbl_wr_in;
  logic [7:0] tbl_addr_in;
  logic [7:0] tbl_data_in;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  int num_errors;
  int n_tests;

  ssr_core ssr_core_i (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .sck_in(sck),
    .cs_n_in(cs_n),
    .si_in(si),
    .so_out(so),
    .so_oe_out(so_oe),
    .tbl_wr_in(tbl_wr_in),
    .tbl_addr_in(tbl_addr_in),
    .tbl_data_in(tbl_data_in)
  );

  ssr_host ssr_host_i (
    .so_in(so),
    .so_oe_in(so_oe),
    .sck_out(sck),
    .cs_n_out(cs_n),
    .si_out(si)
  );

  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] tv(input int a);
    return 8'(a * 37 + 11);
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_read(input int adr, input int nb);
    for (int k = 0; k < nb; k++)
      chk_byte(ssr_host_i.rx[k], tv((adr + k) % 256));
    chk_byte(8'(ssr_host_i.early_oe), 8'h00);
    chk_byte(8'(ssr_host_i.lost_oe), 8'h00);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_basic;
    ssr_host_i.xfer(8'h5A, 24'hA5_0010, 24);
    chk_read(16, 3); // Short stream, quiet header
    #200;
    $display("t_basic done");
  endtask

  task automatic t_full;
    ssr_host_i.xfer(8'h5A, 24'h00_0080, 257 * 8);
    chk_read(128, 257); // Whole table with gapless wrap
    #200;
    $display("t_full done");
  endtask

  task automatic t_abort;
    logic [7:0] b;
    ssr_host_i.xfer(8'h5A, 24'h00_0040, 12);
    #1;
    chk_bit(so_oe, 1'b0); // Select high floats output
    b = tv(65);
    chk_read(64, 1); // First byte intact
    chk_byte({4'h0, ssr_host_i.rx[1][3:0]}, {4'h0, b[7:4]}); // Cut mid-byte
    #200;
    $display("t_abort done");
  endtask

  task automatic t_bad;
    logic [7:0] opc [0:1];
    opc = '{8'h5B, 8'hDA};
    for (int i = 0; i < 2; i++)
    begin
      ssr_host_i.xfer(opc[i], 24'h00_0000, 16);
      chk_byte(8'(ssr_host_i.lost_oe), 8'h10); // Foreign opcode stays silent
      chk_byte(8'(ssr_host_i.early_oe), 8'h00);
      #200;
    end
    $display("t_bad done");
  endtask

  task automatic t_slow;
    ssr_host_i.hp = 100;
    ssr_host_i.xfer(8'h5A, 24'h00_00FF, 16);
    chk_read(255, 2); // Slow clock read
    ssr_host_i.hp = 32;
    #200;
    $display("t_slow done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    nrst_in = 1'b0;
    tbl_wr_in = 1'b0;
    tbl_addr_in = 8'h00;
    tbl_data_in = 8'h00;
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    for (int a = 0; a < 256; a++)
    begin
      @(posedge mclk_in);
      tbl_wr_in <= 1'b1;
      tbl_addr_in <= 8'(a);
      tbl_data_in <= tv(a);
    end
    @(posedge mclk_in);
    tbl_wr_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk_bit(so_oe, 1'b0); // Idle output floats
    t_basic();
    t_full();
    t_abort();
    t_bad();
    t_slow();
    end_sim();
  end

  initial
  begin
    #400000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
